// ### src/sbl_loader.sv
// Notes on behaviour
// - boot mode pins at reset release start the loader, else user run
// - host streams zero bytes; low time sets the baud divisor
// - frames are 8 data bits, one stop bit, no parity
// - about 100 clock states pass before low-time measuring starts
// - after rate match one zero byte goes to the host
// - a received 0x55 is answered with 0xAA
// - two length bytes, upper first, each echoed
// - N program bytes, each echoed and stored in order; code echoes but does not store those at counts 0x3800..0x77FF
// - program lands in FF8800..FFBFFF; FF8000..FF87FF stays loader's; code wraps counts from 0x7800 to 000000 upward and stores them there
// - non-blank flash is erased; 0xAA on success, 0xFF and halt on fail
// - after good erase check, branch to loaded program start
// - before branch clear serial enables, keep divisor, transmit line high
// - general registers are left undefined at the branch
// - watchdog overflow reset also ends boot mode
// - all interrupts blocked while flash is erased or programmed
// - matching guaranteed only for 19200/9600 bps at 8..25 MHz
//
// Implementation choices: the register addresses and register access over Avalon-MM.
module sbl_loader
   import sbl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // straps and watchdog
   input wire logic [2:0] mode_select_pins_i,
   input wire logic wdt_overflow_i,
   // serial channel
   input wire logic rxd_i,
   output logic txd_o,
   // avalon-mm slave
   input wire sbl_avs_req_t avs_req_i,
   output logic avs_waitrequest_o,
   output logic [31:0] avs_readdata_o,
   // program store
   output logic ram_we_o,
   output logic [23:0] ram_addr_o,
   output logic [7:0] ram_wdata_o,
   // flash control
   input wire sbl_flash_st_t flash_st_i,
   output logic flash_erase_req_o,
   output logic irq_block_o,
   // branch to loaded program
   output logic branch_o,
   output logic [23:0] branch_addr_o
);
   sbl_state_t state_reg;
   logic boot_reg;
   logic [6:0] wait_cnt_reg;
   logic [3:0] pre9_reg;
   logic [15:0] div_reg; // wide enough for slow hosts at fast clocks
   logic [1:0] scr_reg;
   logic [15:0] len_reg;
   logic [15:0] cnt_reg;
   logic q_go_reg;
   logic [7:0] q_data_reg;
   logic rx_busy_reg;
   logic [15:0] rx_tmr_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_sh_reg;
   logic rx_done_reg;
   logic [7:0] rx_data_reg;
   logic tx_busy_reg;
   logic [15:0] tx_tmr_reg;
   logic [3:0] tx_bit_reg;
   logic [9:0] tx_sh_reg;
   logic tx_line_reg;
   logic tx_pend_reg;
   logic [7:0] tx_pend_data_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic bus_req;
   logic bus_wr;
   logic tx_quiet;
   logic [23:0] store_addr;

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
      reg_hit = (addr[3:2] == off[3:2]);
   endfunction

   function automatic logic [15:0] period_load(input logic [15:0] div);
      period_load = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
   endfunction

   assign bus_req = avs_req_i.read | avs_req_i.write;
   assign bus_wr = avs_req_i.write & ack_reg;
   assign avs_waitrequest_o = bus_req & ~ack_reg;
   assign avs_readdata_o = rdata_reg;
   assign txd_o = tx_line_reg;
   assign tx_quiet = ~tx_busy_reg & ~tx_pend_reg & ~q_go_reg;
   assign store_addr = PROG_BASE + {8'h00, cnt_reg};
   assign branch_addr_o = PROG_BASE;
   assign flash_erase_req_o = (state_reg == S_ERASE);
   // interrupts stay off for the whole loader run, erase included
   assign irq_block_o = boot_reg & (state_reg != S_RUN) & (state_reg != S_USER);
   // general registers are not touched; only control passes
   assign branch_o = (state_reg == S_RUN);

   // bus slave: one wait state, data ready at the accepting edge
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= bus_req & ~ack_reg;
         if (avs_req_i.read & ~ack_reg)
         begin
            if (reg_hit(avs_req_i.address, REG_STATUS))
               rdata_reg <= {26'h0, boot_reg, branch_o, state_reg};
            else if (reg_hit(avs_req_i.address, REG_BAUD))
               rdata_reg <= {16'h0000, div_reg};
            else if (reg_hit(avs_req_i.address, REG_SCR))
               rdata_reg <= {30'h0, scr_reg};
            else
               rdata_reg <= {len_reg, cnt_reg};
         end
      end
   end

   // loader sequence, baud divisor and serial control
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_reg <= S_STRAP;
         boot_reg <= 1'b0;
         wait_cnt_reg <= 7'h00;
         pre9_reg <= 4'h0;
         div_reg <= BAUD_RST;
         scr_reg <= SCR_RST;
         len_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
         q_go_reg <= 1'b0;
         q_data_reg <= 8'h00;
         ram_we_o <= 1'b0;
         ram_addr_o <= 24'h000000;
         ram_wdata_o <= 8'h00;
      end
      else
      begin
         q_go_reg <= 1'b0;
         ram_we_o <= 1'b0;
         if (bus_wr && reg_hit(avs_req_i.address, REG_BAUD))
            div_reg <= avs_req_i.writedata[15:0];
         if (bus_wr && reg_hit(avs_req_i.address, REG_SCR))
            scr_reg <= avs_req_i.writedata[1:0];
         case (state_reg)
            S_STRAP:
            begin
               // pins caught after release, not under reset
               if ((mode_select_pins_i == BOOT_MD_A) || (mode_select_pins_i == BOOT_MD_B))
               begin
                  boot_reg <= 1'b1;
                  state_reg <= S_WAIT;
               end
               else
                  state_reg <= S_USER;
            end
            S_WAIT:
            begin
               wait_cnt_reg <= wait_cnt_reg + 7'h01;
               if (wait_cnt_reg == STARTUP_CYC - 7'h01)
                  state_reg <= S_IDLE;
            end
            S_IDLE:
               if (rxd_i)
                  state_reg <= S_ARM;
            S_ARM:
               if (!rxd_i)
               begin
                  pre9_reg <= 4'h1;
                  div_reg <= 16'h0000;
                  state_reg <= S_MEAS;
               end
            S_MEAS:
            begin
               // divide low time by nine on the fly, no divider needed
               if (pre9_reg == LOW_BITS - 4'h1)
               begin
                  pre9_reg <= 4'h0;
                  div_reg <= div_reg + 16'h0001;
               end
               else
                  pre9_reg <= pre9_reg + 4'h1;
               if (rxd_i)
               begin
                  if (div_reg == 16'h0000)
                     state_reg <= S_IDLE;
                  else
                  begin
                     scr_reg <= SCR_LOADER;
                     q_go_reg <= 1'b1;
                     q_data_reg <= ZERO_BYTE;
                     state_reg <= S_HAND;
                  end
               end
            end
            S_HAND:
               // leftover zero bytes are dropped until the request
               if (rx_done_reg && rx_data_reg == SYNC_REQ)
               begin
                  q_go_reg <= 1'b1;
                  q_data_reg <= SYNC_ACK;
                  state_reg <= S_LENH;
               end
            S_LENH:
               if (rx_done_reg)
               begin
                  len_reg[15:8] <= rx_data_reg;
                  q_go_reg <= 1'b1;
                  q_data_reg <= rx_data_reg;
                  state_reg <= S_LENL;
               end
            S_LENL:
               if (rx_done_reg)
               begin
                  len_reg[7:0] <= rx_data_reg;
                  q_go_reg <= 1'b1;
                  q_data_reg <= rx_data_reg;
                  cnt_reg <= 16'h0000;
                  if ({len_reg[15:8], rx_data_reg} == 16'h0000)
                     state_reg <= S_CHECK;
                  else
                     state_reg <= S_DATA;
               end
            S_DATA:
               if (rx_done_reg)
               begin
                  q_go_reg <= 1'b1;
                  q_data_reg <= rx_data_reg;
                  // bytes at counts 0x3800..0x77FF are echoed but not stored; from 0x7800 the address wraps to 000000 and they are stored
                  if (store_addr <= PROG_LAST)
                  begin
                     ram_we_o <= 1'b1;
                     ram_addr_o <= store_addr;
                     ram_wdata_o <= rx_data_reg;
                  end
                  cnt_reg <= cnt_reg + 16'h0001;
                  if (cnt_reg == len_reg - 16'h0001)
                     state_reg <= S_CHECK;
               end
            S_CHECK:
               if (tx_quiet)
               begin
                  if (flash_st_i.blank)
                  begin
                     q_go_reg <= 1'b1;
                     q_data_reg <= SYNC_ACK;
                     state_reg <= S_REPORT;
                  end
                  else
                     state_reg <= S_ERASE;
               end
            S_ERASE:
               if (flash_st_i.fail)
               begin
                  q_go_reg <= 1'b1;
                  q_data_reg <= ERASE_FAIL;
                  state_reg <= S_HALT;
               end
               else if (flash_st_i.done)
               begin
                  q_go_reg <= 1'b1;
                  q_data_reg <= SYNC_ACK;
                  state_reg <= S_REPORT;
               end
            S_REPORT:
               if (tx_quiet)
               begin
                  scr_reg <= SCR_RST;
                  state_reg <= S_RUN;
               end
            S_HALT, S_RUN, S_USER:
               state_reg <= state_reg;
            default:
               state_reg <= S_STRAP;
         endcase
         // overflow reset leaves boot mode for good
         if (wdt_overflow_i)
         begin
            boot_reg <= 1'b0;
            state_reg <= S_USER;
         end
      end
   end

   // receiver: start bit checked mid-bit, stop bit must be high
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_busy_reg <= 1'b0;
         rx_tmr_reg <= 16'h0000;
         rx_bit_reg <= 4'h0;
         rx_sh_reg <= 8'h00;
         rx_done_reg <= 1'b0;
         rx_data_reg <= 8'h00;
      end
      else
      begin
         rx_done_reg <= 1'b0;
         if (!scr_reg[SCR_RX_BIT])
            rx_busy_reg <= 1'b0;
         else if (!rx_busy_reg)
         begin
            if (!rxd_i)
            begin
               rx_busy_reg <= 1'b1;
               rx_tmr_reg <= {1'b0, div_reg[15:1]};
               rx_bit_reg <= 4'h0;
            end
         end
         else if (rx_tmr_reg != 16'h0000)
            rx_tmr_reg <= rx_tmr_reg - 16'h0001;
         else
         begin
            rx_tmr_reg <= period_load(div_reg);
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && rxd_i)
               rx_busy_reg <= 1'b0;
            else if (rx_bit_reg == FRAME_LAST)
            begin
               rx_busy_reg <= 1'b0;
               rx_done_reg <= rxd_i;
               rx_data_reg <= rx_sh_reg;
            end
            else if (rx_bit_reg != 4'h0)
               rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]};
         end
      end
   end

   // transmitter with one byte of pending echo
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_busy_reg <= 1'b0;
         tx_tmr_reg <= 16'h0000;
         tx_bit_reg <= 4'h0;
         tx_sh_reg <= 10'h3FF;
         tx_line_reg <= 1'b1;
         tx_pend_reg <= 1'b0;
         tx_pend_data_reg <= 8'h00;
      end
      else
      begin
         if (!tx_busy_reg)
         begin
            tx_line_reg <= 1'b1;
            if (tx_pend_reg && scr_reg[SCR_TX_BIT])
            begin
               tx_pend_reg <= 1'b0;
               tx_busy_reg <= 1'b1;
               tx_sh_reg <= {1'b1, tx_pend_data_reg, 1'b0};
               tx_bit_reg <= 4'h0;
               tx_tmr_reg <= period_load(div_reg);
               tx_line_reg <= 1'b0;
            end
         end
         else if (tx_tmr_reg != 16'h0000)
            tx_tmr_reg <= tx_tmr_reg - 16'h0001;
         else if (tx_bit_reg == FRAME_LAST)
         begin
            tx_busy_reg <= 1'b0;
            tx_line_reg <= 1'b1;
         end
         else
         begin
            tx_tmr_reg <= period_load(div_reg);
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            tx_line_reg <= tx_sh_reg[1];
         end
         // new byte wins over the start that empties the slot
         if (q_go_reg)
         begin
            tx_pend_reg <= 1'b1;
            tx_pend_data_reg <= q_data_reg;
         end
      end
   end

   AST_STARTUP_WAIT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == S_WAIT) ##1 (state_reg == S_IDLE) |-> $past(wait_cnt_reg) == 7'd99)
      else $error("left start-up wait early");
   AST_ZERO_AFTER_MATCH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == S_MEAS) ##1 (state_reg == S_HAND) |-> q_go_reg && q_data_reg == 8'h00)
      else $error("no zero byte after rate match");
   AST_ACK_ON_REQ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == S_HAND && rx_done_reg && rx_data_reg == 8'h55 && !wdt_overflow_i)
      |=> q_go_reg && q_data_reg == 8'hAA ##1 tx_pend_reg)
      else $error("0x55 not answered with 0xAA");
   AST_ECHO_STORE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == S_DATA && rx_done_reg && cnt_reg == 16'h0000 && !wdt_overflow_i)
      |=> q_go_reg && q_data_reg == $past(rx_data_reg) && ram_we_o
      && ram_wdata_o == $past(rx_data_reg))
      else $error("data byte not echoed and stored");
   AST_RAM_WINDOW: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ram_we_o |-> ram_addr_o >= 24'hFF8800 && ram_addr_o <= 24'hFFBFFF)
      else $error("store outside program window");
   AST_ERASE_FAIL: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == S_ERASE && flash_st_i.fail && !wdt_overflow_i)
      |=> state_reg == S_HALT && q_data_reg == 8'hFF ##1 state_reg == S_HALT)
      else $error("erase failure not reported");
   AST_IRQ_BLOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      flash_erase_req_o |-> irq_block_o)
      else $error("interrupts open during erase");
   AST_BRANCH_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(branch_o) |-> scr_reg == 2'h0 && txd_o && div_reg == $past(div_reg))
      else $error("serial not quiet at branch");
   AST_START_BIT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(tx_busy_reg) |-> !txd_o ##1 (tx_busy_reg || txd_o))
      else $error("frame did not open with start bit");
   AST_WDT_EXIT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wdt_overflow_i |=> state_reg == S_USER && !boot_reg)
      else $error("watchdog did not end boot mode");
endmodule // sbl_loader

// ### src/sbl_pkg.sv
package sbl_pkg;
   // start-up delay, in clock states
   localparam int unsigned STARTUP_STATES = 100;
   localparam logic [6:0] STARTUP_CYC = 7'(STARTUP_STATES);
   // start bit plus eight zero data bits
   localparam logic [3:0] LOW_BITS = 4'h9;
   localparam logic [3:0] FRAME_LAST = 4'h9;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] SYNC_REQ = 8'h55;
   localparam logic [7:0] SYNC_ACK = 8'hAA;
   localparam logic [7:0] ERASE_FAIL = 8'hFF;
   localparam logic [23:0] LOADER_BASE = 24'hFF8000;
   localparam logic [23:0] PROG_BASE = 24'hFF8800;
   localparam logic [23:0] PROG_LAST = 24'hFFBFFF;
   localparam logic [2:0] BOOT_MD_A = 3'h3;
   localparam logic [2:0] BOOT_MD_B = 3'h2;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_BAUD = 4'h4;
   localparam logic [3:0] REG_SCR = 4'h8;
   localparam logic [3:0] REG_COUNT = 4'hC;
   localparam int SCR_RX_BIT = 0;
   localparam int SCR_TX_BIT = 1;
   localparam logic [15:0] BAUD_RST = 16'h0000;
   localparam logic [1:0] SCR_RST = 2'h0;
   localparam logic [1:0] SCR_LOADER = 2'h3;
   typedef enum logic [3:0] {
      S_STRAP, S_USER, S_WAIT, S_IDLE, S_ARM, S_MEAS, S_HAND, S_LENH,
      S_LENL, S_DATA, S_CHECK, S_ERASE, S_REPORT, S_HALT, S_RUN
   } sbl_state_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } sbl_avs_req_t;
   typedef struct packed {
      logic blank;
      logic done;
      logic fail;
   } sbl_flash_st_t;
endpackage

// ### test/sbl_host.sv
// serial host on the far side of the loader; bit time shortened to keep runs brief
module sbl_host #(
   parameter int BIT = 40 // outside the guaranteed rates, on purpose
) (
   // clock
   input wire logic clk_i,
   // serial lines
   input wire logic txd_i,
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle high between frames and across reset release
   initial rxd_o = 1'b1;

   // start, eight data bits lsb first, one stop, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd_o <= fr[i];
         repeat (BIT) @(posedge clk_i);
      end
   endtask

   // mid-bit sampling tolerates the device divisor being one cycle short
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (txd_i !== 1'b0 && n < 4000)
      begin
         @(posedge clk_i);
         n++;
      end
      repeat (BIT / 2) @(posedge clk_i);
      ok = (n < 4000) && (txd_i === 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge clk_i);
         b[i] = txd_i;
      end
      repeat (BIT) @(posedge clk_i);
      ok = ok && (txd_i === 1'b1);
   endtask
endmodule // sbl_host

// ### test/tb.sv
module tb
   import sbl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BIT = 40;
   localparam logic [7:0] PROG [3] = '{8'hA5, 8'h55, 8'hC3};

   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [2:0] mode_select_pins = BOOT_MD_A;
   logic wdt_overflow = 1'b0;
   logic rxd;
   logic txd;
   sbl_avs_req_t avs_req = '0;
   logic waitreq;
   logic [31:0] readdata;
   logic ram_we;
   logic [23:0] ram_addr;
   logic [7:0] ram_wdata;
   sbl_flash_st_t flash_st = '{blank: 1'b1, done: 1'b1, fail: 1'b0};
   logic erase_req;
   logic irq_block;
   logic branch;
   logic [23:0] branch_addr;
   int bad_count = 0;
   int samples_checked = 0;
   int ns = 0;
   logic saw_erase = 1'b0;
   logic [23:0] st_addr [8];
   logic [7:0] st_data [8];

   initial forever #10 sys_clk_i = ~sys_clk_i;

   sbl_loader DUT (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .mode_select_pins_i(mode_select_pins), .wdt_overflow_i(wdt_overflow),
      .rxd_i(rxd), .txd_o(txd),
      .avs_req_i(avs_req), .avs_waitrequest_o(waitreq), .avs_readdata_o(readdata),
      .ram_we_o(ram_we), .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata),
      .flash_st_i(flash_st), .flash_erase_req_o(erase_req), .irq_block_o(irq_block),
      .branch_o(branch), .branch_addr_o(branch_addr)
   );

   sbl_host #(.BIT(BIT)) host (.clk_i(sys_clk_i), .txd_i(txd), .rxd_o(rxd));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // program store and erase monitors
   always @(posedge sys_clk_i)
   begin
      if (ram_we === 1'b1 && ns < 8)
      begin
         st_addr[ns] = ram_addr;
         st_data[ns] = ram_wdata;
         ns++;
      end
      if (erase_req === 1'b1)
      begin
         saw_erase = 1'b1;
         check(irq_block, 1);
      end
   end

   // one avalon access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w,
                      output logic [31:0] d);
      int n;
      n = 0;
      d = 32'h0000_0000;
      avs_req <= '{read: ~wr, write: wr, address: a, writedata: w};
      // read right at the edge, before that edge's register updates land
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (waitreq !== 1'b0 && n < 50);
      if (waitreq !== 1'b0)
      begin
         bad_count++;
         finish_test();
      end
      else
      begin
         d = readdata;
         avs_req <= '0;
         // one idle edge keeps back-to-back requests apart
         @(posedge sys_clk_i);
      end
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      check(d, exp);
   endtask

   // reset of n cycles with the given straps; straps then stay steady
   task automatic do_reset(input logic [2:0] pins, input int n);
      rstn_i <= 1'b0;
      mode_select_pins <= pins;
      repeat (n) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      ns = 0;
      saw_erase = 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic xfer(input logic [7:0] b, input logic [7:0] exp);
      logic [7:0] got;
      logic ok;
      fork
         host.send_byte(b);
         host.recv_byte(got, ok);
      join
      check({ok, got}, {1'b1, exp});
   endtask

   task automatic boot_run(input logic bl, input logic fl, input logic [7:0] rep);
      logic [7:0] got;
      logic ok;
      flash_st <= '{blank: bl, done: ~fl, fail: fl};
      do_reset(BOOT_MD_B, 20);
      repeat (110) @(posedge sys_clk_i);
      fork
         begin
            host.send_byte(ZERO_BYTE);
            host.send_byte(ZERO_BYTE);
         end
         host.recv_byte(got, ok);
      join
      check({ok, got}, {1'b1, ZERO_BYTE});
      xfer(SYNC_REQ, SYNC_ACK);
      xfer(8'h00, 8'h00);
      xfer(8'h03, 8'h03);
      for (int i = 0; i < 3; i++)
         xfer(PROG[i], PROG[i]);
      check(ns, 3);
      for (int i = 0; i < 3; i++)
         check({st_addr[i], st_data[i]}, {PROG_BASE + 24'(i), PROG[i]});
      rd_chk(REG_COUNT, {16'h0003, 16'h0003});
      host.recv_byte(got, ok);
      check({ok, got}, {1'b1, rep});
      check(saw_erase, !bl);
      repeat (2 * BIT) @(posedge sys_clk_i);
   endtask

   logic [31:0] d;

   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);

      // blank flash: straight report and branch
      boot_run(1'b1, 1'b0, SYNC_ACK);
      check({branch, branch_addr}, {1'b1, PROG_BASE});
      check({txd, irq_block}, 2'h2);
      rd_chk(REG_STATUS, 32'h0000_003E);
      rd_chk(REG_SCR, 32'h0);
      bus(1'b0, REG_BAUD, 32'h0, d);
      check(d >= 32'd39 && d <= 32'd40, 1);
      bus(1'b1, REG_SCR, 32'h3, d);
      rd_chk(4'h9, 32'h3);
      bus(1'b1, REG_STATUS, 32'h0, d);
      rd_chk(REG_STATUS, 32'h0000_003E);
      $display("test blank flash done");

      // written flash, erase succeeds
      boot_run(1'b0, 1'b0, SYNC_ACK);
      check(branch, 1);
      $display("test erase done");

      // erase fails: report and halt without branching
      boot_run(1'b0, 1'b1, ERASE_FAIL);
      check({branch, erase_req}, 2'h0);
      rd_chk(REG_STATUS, 32'h0000_002D);
      $display("test erase failure done");

      // non-boot straps run the user program
      do_reset(3'h4, 20);
      repeat (200) @(posedge sys_clk_i);
      check({txd, irq_block, branch}, 3'h4);
      rd_chk(REG_STATUS, 32'h0000_0001);
      $display("test user mode done");

      // watchdog overflow in mid-handshake leaves boot mode
      do_reset(BOOT_MD_A, 20);
      repeat (150) @(posedge sys_clk_i);
      host.send_byte(ZERO_BYTE);
      wdt_overflow <= 1'b1;
      @(posedge sys_clk_i);
      wdt_overflow <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(REG_STATUS, 32'h0000_0001);
      check(irq_block, 0);
      $display("test watchdog done");
      finish_test();
   end

   initial
   begin
      #1900000;
      bad_count++;
      finish_test();
   end
endmodule // tb
